//--- rtl/lcd_bias_rail_sequencer.sv
// bias rail sequencing, fault supervision, gate shaping switches and register port
//
// The address map and strobed register access were decided locally.
module lcd_bias_rail_sequencer #(
    parameter int unsigned FAULT_FILTER_TICKS = lcd_bias_pkg::FAULT_FILTER_TICKS
) (
    input  wire  logic                      mclk,
    input  wire  logic                      rst_n,
    input  wire  lcd_bias_pkg::reg_bus_s    bus,
    output logic [31:0]                     reg_rdata,
    input  wire  lcd_bias_pkg::sense_s      sense_in,
    output lcd_bias_pkg::rail_cfg_s         rail_cfg,
    output lcd_bias_pkg::rail_drive_s       rail_drive,
    output lcd_bias_pkg::switch_s           shaping_switches,
    output logic                            panel_discharge_n_o,
    output logic                            panel_discharge_n_oe,
    output logic                            sys_reset_n_o,
    output logic                            sys_reset_n_oe,
    output logic                            fault_shutdown
);
    import lcd_bias_pkg::*;

    seq_state_s           cur;
    seq_state_s           nxt;
    logic [NUM_RAILS-1:0] rail_en;

    // ==========================================================
    // helpers
    function automatic time_t clamp_time(input int unsigned idx, input time_t v);
        time_t lo;
        time_t hi;
        lo = time_t'(TIME_MIN_US[idx]);
        hi = time_t'(TIME_MAX_MS[idx] * US_PER_MS);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [NUM_RAILS-1:0] enables(input seq_e s);
        logic [NUM_RAILS-1:0] e;
        e = '0;
        case (s)
            S_GL_DLY: begin
                e = 3'h1;
            end
            S_GL_RAMP: begin
                e = 3'h3;
            end
            S_GH_RAMP, S_SHAPE_DLY, S_RUN: begin
                e = 3'h7;
            end
            default: begin
                e = '0;
            end
        endcase
        return e;
    endfunction

    assign rail_en = enables(cur.seq);

    // ==========================================================
    // next state
    always_comb begin
        sense_s s;
        logic   tick;
        logic   fault_any;
        logic   count_en;
        time_t  lim;
        seq_e   target;
        time_t  ss;
        time_t  acc_sum;
        logic [NUM_RAILS-1:0] watch;
        s = cur.sync2;
        tick = 1'b0;
        fault_any = 1'b0;
        count_en = 1'b0;
        lim = '0;
        target = cur.seq;
        ss = '0;
        acc_sum = '0;
        watch = '0;
        nxt = cur;

        // the first stage feeds only the second
        nxt.sync1 = sense_in;
        nxt.sync2 = cur.sync1;

        tick = (cur.tick_cnt == tick_t'(TICK_CYCLES - 1));
        nxt.tick_cnt = tick ? '0 : cur.tick_cnt + 1'b1;

        // register writes; times are clamped to their legal span
        if (bus.wr) begin
            if (bus.addr == ADDR_RAIL_CFG) begin
                nxt.cfg.freq_sel = freq_e'(bus.wdata[CFG_FREQ_LSB +: 2]);
                nxt.cfg.analog_code = bus.wdata[CFG_AN_LSB +: 5];
                nxt.cfg.gate_high_code = bus.wdata[CFG_GH_LSB +: 4];
                nxt.cfg.gate_low_code = bus.wdata[CFG_GL_LSB +: 4];
                nxt.cfg.threshold_sel = bus.wdata[CFG_THR_LSB +: 3];
            end
            for (int unsigned t = 0; t < NUM_TIMES; t++) begin
                if (bus.addr == addr_t'(ADDR_TIME_BASE + 4 * t)) begin
                    nxt.times[t] = clamp_time(t, bus.wdata[16:0]);
                end
            end
        end

        // read data stands for exactly one cycle
        nxt.rdata = '0;
        if (bus.rd) begin
            if (bus.addr == ADDR_RAIL_CFG) begin
                nxt.rdata[CFG_FREQ_LSB +: 2] = cur.cfg.freq_sel;
                nxt.rdata[CFG_AN_LSB +: 5] = cur.cfg.analog_code;
                nxt.rdata[CFG_GH_LSB +: 4] = cur.cfg.gate_high_code;
                nxt.rdata[CFG_GL_LSB +: 4] = cur.cfg.gate_low_code;
                nxt.rdata[CFG_THR_LSB +: 3] = cur.cfg.threshold_sel;
            end
            if (bus.addr == ADDR_STATUS) begin
                nxt.rdata[ST_SEQ_LSB +: 3] = cur.seq;
                nxt.rdata[ST_RST_BIT] = cur.rst_released;
                nxt.rdata[ST_DONE_LSB +: 3] = cur.ramp_done;
                nxt.rdata[ST_UV_LSB +: 3] = cur.fault_uv;
                nxt.rdata[ST_SC_LSB +: 3] = cur.fault_sc;
                nxt.rdata[ST_UVLO_BIT] = s.uvlo;
            end
            for (int unsigned t = 0; t < NUM_TIMES; t++) begin
                if (bus.addr == addr_t'(ADDR_TIME_BASE + 4 * t)) begin
                    nxt.rdata[16:0] = cur.times[t];
                end
            end
        end

        // ======================================================
        // soft-start ramps: level climbs 0..255 across the programmed time
        for (int unsigned i = 0; i < NUM_RAILS; i++) begin
            ss = cur.times[RAMP_TIME_IDX[i]];
            if (!rail_en[i]) begin
                nxt.ramp_elapsed[i] = '0;
                nxt.ramp_acc[i] = '0;
                nxt.level[i] = '0;
                nxt.ramp_done[i] = 1'b0;
            end else if (!cur.ramp_done[i]) begin
                if (ss == '0) begin
                    nxt.ramp_done[i] = 1'b1;
                    nxt.level[i] = 8'hFF;
                    nxt.ramp_elapsed[i] = '0;
                end else if (tick) begin
                    nxt.ramp_elapsed[i] = cur.ramp_elapsed[i] + 1'b1;
                    acc_sum = cur.ramp_acc[i] + time_t'(RAMP_STEP);
                    // at most one step per tick; short ramps finish by the forced end
                    if (acc_sum >= ss) begin
                        nxt.ramp_acc[i] = acc_sum - ss;
                        if (cur.level[i] != 8'hFF) begin
                            nxt.level[i] = cur.level[i] + 1'b1;
                        end
                    end else begin
                        nxt.ramp_acc[i] = acc_sum;
                    end
                    if (cur.ramp_elapsed[i] + 1'b1 >= ss) begin
                        nxt.ramp_done[i] = 1'b1;
                        nxt.level[i] = 8'hFF;
                        nxt.ramp_elapsed[i] = '0;
                    end
                end
            end else if (cur.ramp_elapsed[i] < time_t'(SETTLE_CYCLES)) begin
                // synchronised comparators still show the ramp for a few cycles; a false short would latch
                nxt.ramp_elapsed[i] = cur.ramp_elapsed[i] + 1'b1;
            end
        end

        // ======================================================
        // supervision; faults are sticky and only rst_n clears them
        for (int unsigned i = 0; i < NUM_RAILS; i++) begin
            watch[i] = cur.ramp_done[i] && rail_en[i] && (cur.ramp_elapsed[i] >= time_t'(SETTLE_CYCLES));
            if (watch[i] && s.short30[i]) begin
                nxt.fault_sc[i] = 1'b1;
            end
            if (watch[i] && s.under70[i]) begin
                if (tick) begin
                    if (cur.filt_cnt[i] >= time_t'(FAULT_FILTER_TICKS)) begin
                        nxt.fault_uv[i] = 1'b1;
                    end else begin
                        nxt.filt_cnt[i] = cur.filt_cnt[i] + 1'b1;
                    end
                end
            end else begin
                nxt.filt_cnt[i] = '0;
            end
        end
        fault_any = (|cur.fault_uv) || (|cur.fault_sc);

        // ======================================================
        // sequence
        case (cur.seq)
            S_RESET_HOLD: begin
                count_en = s.logic_ready;
                lim = cur.times[T_RST_HOLD];
                target = S_ANALOG_DLY;
            end
            S_ANALOG_DLY: begin
                count_en = 1'b1;
                lim = cur.times[T_ANALOG_DLY];
                target = S_GL_DLY;
            end
            S_GL_DLY: begin
                count_en = 1'b1;
                lim = cur.times[T_GL_DLY];
                target = S_GL_RAMP;
            end
            S_GL_RAMP: begin
                if (cur.ramp_done[RAIL_GATE_LOW]) begin
                    nxt.seq = S_GH_RAMP;
                end
            end
            S_GH_RAMP: begin
                if (cur.ramp_done[RAIL_GATE_HIGH]) begin
                    nxt.seq = S_SHAPE_DLY;
                end
            end
            S_SHAPE_DLY: begin
                count_en = 1'b1;
                lim = cur.times[T_SHAPE_DLY];
                target = S_RUN;
            end
            S_RUN: begin
                nxt.seq = S_RUN;
            end
            S_DOWN: begin
                // a fault keeps the chip down until the next power-on reset
                if (!s.uvlo && !fault_any) begin
                    nxt.seq = S_RESET_HOLD;
                end
            end
            default: begin
                nxt.seq = S_DOWN;
            end
        endcase

        if (count_en) begin
            if (cur.delay_cnt >= lim) begin
                nxt.seq = target;
                nxt.delay_cnt = '0;
            end else if (tick) begin
                nxt.delay_cnt = cur.delay_cnt + 1'b1;
            end
        end
        if (cur.seq == S_RESET_HOLD && nxt.seq == S_ANALOG_DLY) begin
            nxt.rst_released = 1'b1;
        end
        if (s.uvlo || fault_any) begin
            nxt.seq = S_DOWN;
            nxt.delay_cnt = '0;
            nxt.rst_released = 1'b0;
        end

        // ======================================================
        // gate shaping switches
        nxt.shape_prev = s.shaping;
        if (cur.seq == S_RUN && cur.shape_prev && !s.shaping) begin
            nxt.shape_dis = 1'b1;
        end
        if (cur.seq != S_RUN || s.shaping) begin
            nxt.shape_dis = 1'b0;
        end
        nxt.sw = '0;
        case (cur.seq)
            S_RUN: begin
                if (s.shaping) begin
                    nxt.sw.pass = 1'b1;
                end else if (nxt.shape_dis) begin
                    nxt.sw.dis_a = 1'b1;
                    nxt.sw.dis_b = 1'b1;
                end
            end
            S_DOWN: begin
                nxt.sw.pass = 1'b1;
            end
            default: begin
                nxt.sw.clamp = 1'b1;
            end
        endcase

        nxt.panel_low = s.discharge_threshold_sel_low;
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.seq <= S_RESET_HOLD;
            cur.times <= TIMES_RESET;
            cur.sw.clamp <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata = cur.rdata;
    assign rail_cfg = cur.cfg;
    assign rail_drive = '{
        en:                 rail_en,
        ref_level:          cur.level,
        analog_discharge:   !rail_en[RAIL_ANALOG],
        gate_low_discharge: (cur.seq == S_DOWN)
    };
    assign shaping_switches = cur.sw;
    assign panel_discharge_n_o = 1'b0;
    assign panel_discharge_n_oe = cur.panel_low;
    assign sys_reset_n_o = 1'b0;
    assign sys_reset_n_oe = !cur.rst_released;
    assign fault_shutdown = (|cur.fault_uv) || (|cur.fault_sc);

endmodule // lcd_bias_rail_sequencer

//--- rtl/lcd_bias_pkg.sv
// constants, carrier structs and state layout for the bias rail sequencer
package lcd_bias_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned US_PER_MS     = 1000;
    localparam int unsigned FAULT_FILTER_MS    = 50;
    localparam int unsigned FAULT_FILTER_TICKS = FAULT_FILTER_MS * US_PER_MS;
    localparam int unsigned RAMP_STEP     = 256;
    // cycles after a ramp ends before its comparators are trusted (covers the synchroniser)
    localparam int unsigned SETTLE_CYCLES = 3;
    typedef logic [16:0] time_t;
    typedef logic [5:0]  tick_t;
    typedef logic [7:0]  level_t;
    // ==========================================================
    // rails and programmable times
    localparam int unsigned NUM_RAILS = 3;
    localparam int unsigned RAIL_ANALOG = 0;
    localparam int unsigned RAIL_GATE_LOW = 1;
    localparam int unsigned RAIL_GATE_HIGH = 2;
    localparam int unsigned NUM_TIMES = 7;
    localparam int unsigned T_ANALOG_DLY = 0;
    localparam int unsigned T_ANALOG_SS  = 1;
    localparam int unsigned T_GL_DLY     = 2;
    localparam int unsigned T_GL_SS      = 3;
    localparam int unsigned T_GH_SS      = 4;
    localparam int unsigned T_SHAPE_DLY  = 5;
    localparam int unsigned T_RST_HOLD   = 6;
    localparam int unsigned TIME_MIN_US [NUM_TIMES] = '{0, 500, 0, 0, 256, 0, 0};
    localparam int unsigned TIME_MAX_MS [NUM_TIMES] = '{75, 75, 35, 35, 35, 35, 15};
    localparam int unsigned RAMP_TIME_IDX [NUM_RAILS] = '{T_ANALOG_SS, T_GL_SS, T_GH_SS};
    localparam logic [NUM_TIMES-1:0][16:0] TIMES_RESET = {17'h02710, 17'h003E8, 17'h00800,
                                                          17'h007D0, 17'h003E8, 17'h01388, 17'h02710};
    // ==========================================================
    // register map and fields (32-bit words)
    typedef logic [7:0] addr_t;
    localparam addr_t ADDR_RAIL_CFG  = 8'h00;
    localparam addr_t ADDR_TIME_BASE = 8'h04;
    localparam addr_t ADDR_STATUS    = 8'h20;
    localparam int unsigned CFG_FREQ_LSB = 0;
    localparam int unsigned CFG_AN_LSB   = 4;
    localparam int unsigned CFG_GH_LSB   = 12;
    localparam int unsigned CFG_GL_LSB   = 16;
    localparam int unsigned CFG_THR_LSB  = 24;
    localparam int unsigned ST_SEQ_LSB   = 0;
    localparam int unsigned ST_RST_BIT   = 4;
    localparam int unsigned ST_DONE_LSB  = 8;
    localparam int unsigned ST_UV_LSB    = 12;
    localparam int unsigned ST_SC_LSB    = 16;
    localparam int unsigned ST_UVLO_BIT  = 20;
    // ==========================================================
    // types
    typedef enum logic [1:0] {FREQ_400K = 2'h0, FREQ_600K = 2'h1, FREQ_800K = 2'h2, FREQ_1M = 2'h3} freq_e;
    typedef enum logic [2:0] {
        S_RESET_HOLD = 3'h0, S_ANALOG_DLY = 3'h1, S_GL_DLY = 3'h3, S_GL_RAMP = 3'h2,
        S_GH_RAMP = 3'h6, S_SHAPE_DLY = 3'h7, S_RUN = 3'h5, S_DOWN = 3'h4
    } seq_e;
    typedef struct packed {
        addr_t       addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_bus_s;
    typedef struct packed {
        logic                 uvlo;
        logic                 discharge_threshold_sel_low;
        logic                 logic_ready;
        logic [NUM_RAILS-1:0] under70;
        logic [NUM_RAILS-1:0] short30;
        logic                 shaping;
    } sense_s;
    typedef struct packed {
        freq_e      freq_sel;
        logic [4:0] analog_code;
        logic [3:0] gate_high_code;
        logic [3:0] gate_low_code;
        logic [2:0] threshold_sel;
    } rail_cfg_s;
    typedef struct packed {
        logic [NUM_RAILS-1:0]        en;
        logic [NUM_RAILS-1:0][7:0]   ref_level;
        logic                        analog_discharge;
        logic                        gate_low_discharge;
    } rail_drive_s;
    typedef struct packed {
        logic pass;
        logic dis_a;
        logic dis_b;
        logic clamp;
    } switch_s;
    typedef struct packed {
        sense_s                        sync1;
        sense_s                        sync2;
        seq_e                          seq;
        tick_t                         tick_cnt;
        time_t                         delay_cnt;
        logic [NUM_TIMES-1:0][16:0]    times;
        rail_cfg_s                     cfg;
        logic [NUM_RAILS-1:0][16:0]    ramp_elapsed;
        logic [NUM_RAILS-1:0][16:0]    ramp_acc;
        logic [NUM_RAILS-1:0][7:0]     level;
        logic [NUM_RAILS-1:0]          ramp_done;
        logic [NUM_RAILS-1:0][16:0]    filt_cnt;
        logic [NUM_RAILS-1:0]          fault_uv;
        logic [NUM_RAILS-1:0]          fault_sc;
        logic                          shape_prev;
        logic                          shape_dis;
        switch_s                       sw;
        logic                          rst_released;
        logic                          panel_low;
        logic [31:0]                   rdata;
    } seq_state_s;
endpackage

//--- sim/lcd_bias_far_side.sv
// far-side model: rail comparators on the reference levels and timing controller inputs
module lcd_bias_far_side (
    input  wire lcd_bias_pkg::rail_drive_s drive,
    input  wire lcd_bias_pkg::sense_s      cmd,
    output lcd_bias_pkg::sense_s           sense
);
    import lcd_bias_pkg::*;
    // ==========================================================
    // comparators
    // a rail that is off or still low reads below both thresholds;
    // cmd bits add injected faults on top (0xB3 ~ 70%, 0x4D ~ 30% of 255)
    always_comb begin
        sense = cmd;
        for (int i = 0; i < NUM_RAILS; i++) begin
            sense.under70[i] = cmd.under70[i] || !drive.en[i] || drive.ref_level[i] < 8'hB3;
            sense.short30[i] = cmd.short30[i] || !drive.en[i] || drive.ref_level[i] < 8'h4D;
        end
    end
endmodule // lcd_bias_far_side

//--- sim/lcd_bias_rail_sequencer_sva.sv
// port assertions for the bias rail sequencer
module lcd_bias_rail_sequencer_sva (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire lcd_bias_pkg::sense_s      sense_in,
    input wire lcd_bias_pkg::rail_drive_s rail_drive,
    input wire lcd_bias_pkg::switch_s     shaping_switches,
    input wire logic                      panel_discharge_n_oe,
    input wire logic                      sys_reset_n_oe,
    input wire logic                      fault_shutdown
);
    import lcd_bias_pkg::*;
    switch_s    sw;
    logic [2:0] en;
    logic       run;
    logic       quiet;
    assign sw    = shaping_switches;
    assign en    = rail_drive.en;
    assign run   = en == 3'h7 && !sw.clamp && !sense_in.uvlo && !fault_shutdown;
    assign quiet = !sense_in.uvlo && !fault_shutdown && sense_in.short30 == 3'h0 && sense_in.under70 == 3'h0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // rails and faults
    AST_UVLO_OFF: assert property (sense_in.uvlo [*5] |-> en == 3'h0)
        else $error("rails on under lockout");
    AST_AN_DISCH: assert property ($stable(en[0]) |-> rail_drive.analog_discharge == !en[0])
        else $error("analog discharge wrong");
    AST_FAULT_HOLD: assert property (fault_shutdown |=> fault_shutdown)
        else $error("fault not latched");
    AST_FAULT_OFF: assert property (fault_shutdown [*3] |-> en == 3'h0 && sys_reset_n_oe)
        else $error("fault did not shut down");
    AST_SHORT_FAST: assert property ((sense_in.short30[1] && en[1] && rail_drive.ref_level[1] == 8'hFF) [*3]
        |-> ##[0:2] fault_shutdown)
        else $error("short not caught");
    AST_RST_KEEP: assert property (quiet [*4] ##0 !sys_reset_n_oe |=> !sys_reset_n_oe)
        else $error("reset output dropped");
    // ==========================================================
    // shaping switches and panel discharge
    AST_CLAMP_UP: assert property ($rose(en[2]) |-> (sw.clamp && !sw.pass && !sw.dis_a && !sw.dis_b) [*8])
        else $error("clamp not held at power-up");
    AST_DOWN_SW: assert property (sense_in.uvlo [*6] |-> sw.pass && !sw.dis_a && !sw.dis_b && !sw.clamp)
        else $error("power-down switches wrong");
    AST_SHAPE_HI: assert property ((sense_in.shaping && run) [*3] |=> sw.pass && !sw.dis_a && !sw.dis_b)
        else $error("shaping high switches wrong");
    AST_SHAPE_LO: assert property ($fell(sense_in.shaping) && run ##1 (!sense_in.shaping && run) [*2]
        |=> sw.dis_a && sw.dis_b && !sw.pass)
        else $error("shaping fall switches wrong");
    AST_PANEL: assert property ($stable(sense_in.discharge_threshold_sel_low) [*3]
        |=> panel_discharge_n_oe == $past(sense_in.discharge_threshold_sel_low))
        else $error("panel discharge wrong");
endmodule // lcd_bias_rail_sequencer_sva

bind lcd_bias_rail_sequencer lcd_bias_rail_sequencer_sva i_lcd_bias_rail_sequencer_sva (
    .mclk, .rst_n, .sense_in, .rail_drive, .shaping_switches, .panel_discharge_n_oe, .sys_reset_n_oe,
    .fault_shutdown);

//--- sim/lcd_bias_rail_sequencer_tb.sv
// self-checking testbench for the bias rail sequencer
module lcd_bias_rail_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lcd_bias_pkg::*;
    localparam int FILT = 20;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    reg_bus_s    bus = '0;
    sense_s      cmd = '0;
    sense_s      sense;
    logic [31:0] reg_rdata;
    rail_cfg_s   rail_cfg;
    rail_drive_s drv;
    switch_s     sw;
    logic        pd_oe;
    logic        rs_oe;
    logic        pd_o;
    logic        rs_o;
    logic        fault;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    int          seed = 99525;
    int          tm [NUM_TIMES];
    always #12.5 mclk = ~mclk;
    lcd_bias_rail_sequencer #(.FAULT_FILTER_TICKS(FILT)) i_lcd_bias_rail_sequencer (
        .mclk(mclk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata), .sense_in(sense), .rail_cfg(rail_cfg),
        .rail_drive(drv), .shaping_switches(sw), .panel_discharge_n_o(pd_o), .panel_discharge_n_oe(pd_oe),
        .sys_reset_n_o(rs_o), .sys_reset_n_oe(rs_oe), .fault_shutdown(fault));
    lcd_bias_far_side i_lcd_bias_far_side (.drive(drv), .cmd(cmd), .sense(sense));
    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input addr_t a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask
    task automatic rd(input addr_t a, output logic [31:0] d);
        @(posedge mclk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1 d = reg_rdata;
    endtask
    function automatic logic hit(input int w);
        case (w)
            0: return rs_oe === 1'b0;
            1: return drv.en[0] === 1'b1;
            2: return drv.en[1] === 1'b1;
            3: return drv.en[2] === 1'b1;
            4: return drv.ref_level[2] === 8'hFF;
            5: return sw.clamp === 1'b0;
            default: return fault === 1'b1;
        endcase
    endfunction
    task automatic wait_for(input int w, output int n);
        n = 0;
        while (!hit(w) && n < 12000) begin
            @(posedge mclk);
            #1 n++;
        end
    endtask
    // one tick of slack each way plus the input synchroniser
    function automatic logic [31:0] in_win(input int n, input int us);
        return 32'(n >= us * 40 - 44 && n <= us * 40 + 46);
    endfunction
    task automatic power_up();
        int          n;
        logic [31:0] d;
        for (int i = 0; i < NUM_TIMES; i++) begin
            n = $unsigned($random(seed)) % 6;
            tm[i] = n < TIME_MIN_US[i] ? TIME_MIN_US[i] : n;
            wr(ADDR_TIME_BASE + 8'(4 * i), 32'(n));
            rd(ADDR_TIME_BASE + 8'(4 * i), d);
            check(d, 32'(tm[i]));
        end
        @(posedge mclk);
        cmd.logic_ready <= 1'b1;
        cmd.shaping <= 1'b1;
        wait_for(0, n);
        check(in_win(n, tm[T_RST_HOLD]), 1);
        wait_for(1, n);
        check(in_win(n, tm[T_ANALOG_DLY]), 1);
        wait_for(2, n);
        check(in_win(n, tm[T_GL_DLY]), 1);
        wait_for(3, n);
        check(in_win(n, tm[T_GL_SS]), 1);
        wait_for(4, n);
        check(in_win(n, tm[T_GH_SS]), 1);
        wait_for(5, n);
        check(in_win(n, tm[T_SHAPE_DLY]), 1);
        check({drv.ref_level[1], drv.gate_low_discharge, drv.analog_discharge}, 32'h3FC);
        rd(ADDR_STATUS, d);
        check(d[2:0], S_RUN);
        $display("test power-up done");
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] d;
        int          n;
        repeat (7) @(posedge mclk);
        #1 check({rs_oe, sw, drv.analog_discharge, fault, pd_oe, pd_o, rs_o}, 32'h230);
        @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < NUM_TIMES; i++) begin
            rd(ADDR_TIME_BASE + 8'(4 * i), d);
            check(d, 32'(TIMES_RESET[i]));
        end
        @(posedge mclk);
        #1 check(reg_rdata, 0);
        wr(ADDR_STATUS, '1);
        rd(ADDR_STATUS, d);
        check(d, 0);
        rd(8'h40, d);
        check(d, 0);
        wr(ADDR_TIME_BASE + 8'(4 * T_RST_HOLD), 32'd20000);
        rd(ADDR_TIME_BASE + 8'(4 * T_RST_HOLD), d);
        check(d, TIME_MAX_MS[T_RST_HOLD] * US_PER_MS);
        for (int f = 0; f < 4; f++) begin
            d = $random(seed);
            d[1:0] = 2'(f);
            wr(ADDR_RAIL_CFG, d);
            @(posedge mclk);
            #1 check(32'(rail_cfg), 32'({d[1:0], d[CFG_AN_LSB +: 5], d[CFG_GH_LSB +: 4], d[CFG_GL_LSB +: 4],
                d[CFG_THR_LSB +: 3]}));
        end
        $display("test registers done");
        power_up();
        for (int k = 0; k < 12; k++) begin
            @(posedge mclk);
            cmd.shaping <= 1'($random(seed));
            cmd.discharge_threshold_sel_low <= 1'($random(seed));
            repeat (5) @(posedge mclk);
            #1 check({sw, pd_oe}, {cmd.shaping, !cmd.shaping, !cmd.shaping, 1'b0, cmd.discharge_threshold_sel_low});
        end
        check(drv.ref_level[0] === 8'hFF, 0);
        repeat (9900) @(posedge mclk);
        #1 check(drv.ref_level[0], 8'hFF);
        $display("test shaping and soft-start done");
        // gaps in the low indication must restart the filter
        repeat (2) begin
            @(posedge mclk);
            cmd.under70[0] <= 1'b1;
            repeat (FILT * 30) @(posedge mclk);
            cmd.under70[0] <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        #1 check(fault, 0);
        @(posedge mclk);
        cmd.under70[0] <= 1'b1;
        wait_for(6, n);
        check(in_win(n, FILT + 1), 1);
        @(posedge mclk);
        cmd.under70[0] <= 1'b0;
        cmd.logic_ready <= 1'b0;
        cmd.discharge_threshold_sel_low <= 1'b0;
        repeat (50) @(posedge mclk);
        rd(ADDR_STATUS, d);
        check({d[ST_UV_LSB], fault, drv.en, rs_oe}, 32'h31);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 check(fault, 0);
        $display("test under-voltage filter done");
        power_up();
        @(posedge mclk);
        cmd.uvlo <= 1'b1;
        cmd.logic_ready <= 1'b0;
        cmd.shaping <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 check({drv.en, sw, drv.analog_discharge, drv.gate_low_discharge, rs_oe, fault}, 32'h08E);
        @(posedge mclk);
        cmd.uvlo <= 1'b0;
        $display("test lockout done");
        power_up();
        @(posedge mclk);
        cmd.short30[1] <= 1'b1;
        wait_for(6, n);
        check(32'(n < 6), 1);
        @(posedge mclk);
        cmd.short30[1] <= 1'b0;
        rd(ADDR_STATUS, d);
        check({d[ST_SC_LSB +: 3], fault, drv.en}, 32'h28);
        $display("test short circuit done");
        tally_and_finish();
    end
endmodule // lcd_bias_rail_sequencer_tb
